/* File: verilog/avs_pkg.sv */
// Package of constants and types for the presentation timebase block.
package avs_pkg;
  localparam int          STAMP_W          = 33;
  localparam int          CLK_HZ           = 100000000;
  localparam int          TICK_HZ          = 90000;
  localparam int          TICK_DIV         = CLK_HZ / TICK_HZ;
  localparam int          SLEEP_DIV        = 16;
  localparam int          RESET_MIN_CYC    = 10;
  localparam logic [32:0] STAMP_RESET      = 33'h0_0000_0000;
  localparam logic [32:0] STAMP_MAX        = 33'h1_ffff_ffff;
  localparam logic [32:0] PERIOD_DEFAULT   = 33'h0_0000_0bb8;
  typedef enum logic [1:0] {
    AVS_SHOW,
    AVS_DROP,
    AVS_REPEAT
  } avs_verdict_t;
  typedef enum {
    AVS_IDLE,
    AVS_WAIT
  } avs_state_t;
endpackage : avs_pkg

/* File: verilog/avs_divider.sv */
// Parameterised clock-enable divider used for the tick and sleep clocks.
module avs_divider #(
  parameter int DIV = 16
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic run_in,
  output logic      pulse_out
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  wire           at_last = (cnt_reg == LAST);

  assign cnt_next  = !run_in ? '0 : (at_last ? '0 : cnt_reg + CW'(1));
  assign pulse_out = run_in && at_last;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : avs_divider

/* File: verilog/avs_timebase.sv */
// System time counter and picture presentation decision logic.
// Overview of operation
// - A 33-bit system time counter advances at 90 kHz; stamps are 33 bits.
// - A clock reference taken from the stream loads the system time counter.
// - Skip or repeat displays so the stamp stays within one picture period.
// - A stamp below the system time drops the picture.
// - A stamp more than one picture period above the system time repeats the current picture.
// - A stamp is a picture display time or audio start time.
// - After reset state is undefined to software; microcode reload follows.
// - A sleep request clocks the processor at the global clock over 16.
module avs_timebase #(
  parameter logic [32:0] PERIOD_TICKS = avs_pkg::PERIOD_DEFAULT
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        scr_valid_in,
  input  wire logic [32:0] scr_in,
  input  wire logic        pic_valid_in,
  input  wire logic [32:0] pic_pts_in,
  input  wire logic        pic_is_audio_in,
  input  wire logic        sleep_in,
  input  wire logic        test_n_in,
  output logic [32:0]      stc_out,
  output logic             show_out,
  output logic             drop_out,
  output logic             repeat_out,
  output logic             audio_start_out,
  output logic             cpu_clk_en_out,
  output logic             test_mode_out
);
  logic [32:0]          stc_reg;
  logic [32:0]          stc_next;
  logic [32:0]          pts_reg;
  logic                 audio_reg;
  logic                 show_reg;
  logic                 drop_reg;
  logic                 repeat_reg;
  logic                 astart_reg;
  logic [2:0]           test_sync_reg;
  logic                 test_act_reg;
  logic                 test_act_next;
  avs_pkg::avs_state_t  state_reg;
  avs_pkg::avs_state_t  state_next;
  avs_pkg::avs_verdict_t verdict;
  wire                  tick;
  wire                  sleep_tick;

  avs_divider #(
    .DIV (avs_pkg::TICK_DIV)
  ) u_tick (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .run_in    (1'b1),
    .pulse_out (tick)
  );

  // Sleep only divides the processor clock enable; the timebase keeps real time.
  avs_divider #(
    .DIV (avs_pkg::SLEEP_DIV)
  ) u_sleep (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .run_in    (sleep_in),
    .pulse_out (sleep_tick)
  );
  assign cpu_clk_en_out = sleep_in ? sleep_tick : 1'b1;

  // The stream reference wins over a tick in the same cycle so no load is lost.
  assign stc_next = scr_valid_in ? scr_in :
                    tick ? stc_reg + 33'h0_0000_0001 : stc_reg;

  // The pending stamp is checked against each tick-updated time.
  // Comparisons are plain unsigned over all 33 bits, so a stamp just past the wrap
  // reads as early; the stream reference is expected to reload the time first.
  wire pending   = (state_reg == avs_pkg::AVS_WAIT);
  wire [32:0] cur_pts = pending ? pts_reg : pic_pts_in;
  wire cur_audio = pending ? audio_reg : pic_is_audio_in;
  wire judge     = pending || pic_valid_in;
  wire early     = cur_pts < stc_reg;
  wire [32:0] lead = cur_pts - stc_reg;
  wire late_far  = !early && (lead > PERIOD_TICKS);

  assign verdict = early ? avs_pkg::AVS_DROP :
                   late_far ? avs_pkg::AVS_REPEAT :
                   avs_pkg::AVS_SHOW;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      avs_pkg::AVS_IDLE: begin
        if (pic_valid_in && verdict == avs_pkg::AVS_REPEAT) begin
          state_next = avs_pkg::AVS_WAIT;
        end
      end
      avs_pkg::AVS_WAIT: begin
        if (verdict != avs_pkg::AVS_REPEAT) begin
          state_next = avs_pkg::AVS_IDLE;
        end
      end
      default: state_next = avs_pkg::AVS_IDLE;
    endcase
  end

  // The test pin is asynchronous: three flops, and a level counts only once the last
  // two agree, so a one-clock glitch on the pin never reaches the mode output.
  assign test_act_next = (test_sync_reg[2] == test_sync_reg[1]) ?
                         !test_sync_reg[1] : test_act_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // Everything clears to known values, yet software must still treat the state
      // as undefined and reload its microcode before use.
      stc_reg       <= avs_pkg::STAMP_RESET;
      pts_reg       <= avs_pkg::STAMP_RESET;
      audio_reg     <= 1'b0;
      state_reg     <= avs_pkg::AVS_IDLE;
      show_reg      <= 1'b0;
      drop_reg      <= 1'b0;
      repeat_reg    <= 1'b0;
      astart_reg    <= 1'b0;
      test_sync_reg <= 3'h7;
      test_act_reg  <= 1'b0;
    end else begin
      stc_reg       <= stc_next;
      state_reg     <= state_next;
      test_sync_reg <= {test_sync_reg[1:0], test_n_in};
      test_act_reg  <= test_act_next;
      if (!pending && pic_valid_in) begin
        pts_reg   <= pic_pts_in;
        audio_reg <= pic_is_audio_in;
      end
      show_reg   <= judge && verdict == avs_pkg::AVS_SHOW && !cur_audio;
      astart_reg <= judge && verdict == avs_pkg::AVS_SHOW && cur_audio;
      drop_reg   <= judge && verdict == avs_pkg::AVS_DROP;
      // A repeat goes out once per tick, the only moment other than a stream reference load that the time can close the gap.
      repeat_reg <= judge && verdict == avs_pkg::AVS_REPEAT && tick;
    end
  end

  assign stc_out         = stc_reg;
  assign show_out        = show_reg;
  assign drop_out        = drop_reg;
  assign repeat_out      = repeat_reg;
  assign audio_start_out = astart_reg;
  assign test_mode_out   = test_act_reg;

  chk_stc_scr_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    scr_valid_in |=> stc_out == $past(scr_in))
    else $error("system time not loaded from reference");

  chk_stc_tick_adv: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (tick && !scr_valid_in) |=> stc_out == $past(stc_out) + 33'h0_0000_0001)
    else $error("system time did not advance on tick");

  chk_stc_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!tick && !scr_valid_in) |=> $stable(stc_out))
    else $error("system time moved without cause");

  chk_drop_early: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!pending && pic_valid_in && pic_pts_in < stc_out) |=> drop_out)
    else $error("early picture not dropped");

  chk_late_wait: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!pending && pic_valid_in && pic_pts_in > stc_out + PERIOD_TICKS
     && stc_out < 33'h1_0000_0000) |=> pending && !show_out)
    else $error("late picture not held");

  chk_show_near: assert property (@(posedge clk_in) disable iff (!nrst_in)
    show_out |-> !drop_out && !repeat_out && !audio_start_out)
    else $error("conflicting display verdicts");

  chk_sleep_rate: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (sleep_in && cpu_clk_en_out) ##1 sleep_in[*8] |-> !cpu_clk_en_out)
    else $error("sleep clock faster than divide by sixteen");

  chk_awake_clock: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !sleep_in |-> cpu_clk_en_out)
    else $error("processor clock gated while awake");

  chk_tick_period: assert property (@(posedge clk_in) disable iff (!nrst_in)
    tick |=> !tick [*8])
    else $error("tick faster than expected");

  // The checks below restate the rules from the ports plus pending, pts_reg and tick, not from the verdict wires.
  chk_show_window: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!pending && pic_valid_in && !pic_is_audio_in && pic_pts_in >= stc_out
     && pic_pts_in - stc_out <= PERIOD_TICKS) |=> show_out)
    else $error("picture inside the window not shown");

  chk_audio_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!pending && pic_valid_in && pic_is_audio_in && pic_pts_in >= stc_out
     && pic_pts_in - stc_out <= PERIOD_TICKS) |=> audio_start_out && !show_out)
    else $error("audio unit inside the window not started");

  chk_wait_show: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (pending && pts_reg >= stc_out && pts_reg - stc_out <= PERIOD_TICKS)
    |=> !pending && (show_out || audio_start_out))
    else $error("waiting unit not released inside the window");

  chk_repeat_tick: assert property (@(posedge clk_in) disable iff (!nrst_in)
    repeat_out |-> $past(tick) && pending)
    else $error("repeat issued off a tick or without a waiting unit");

  chk_wait_refuse: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (pending && pic_valid_in) |=> pts_reg == $past(pts_reg))
    else $error("new unit taken while one is waiting");

  chk_stc_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (stc_out == avs_pkg::STAMP_MAX && tick && !scr_valid_in) |=> stc_out == avs_pkg::STAMP_RESET)
    else $error("system time did not wrap to zero");

  chk_test_enter: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !test_n_in [*4] |=> test_mode_out)
    else $error("test mode not entered after a steady low pin");

  chk_test_leave: assert property (@(posedge clk_in) disable iff (!nrst_in)
    test_n_in [*4] |=> !test_mode_out)
    else $error("test mode held after a steady high pin");
endmodule : avs_timebase

/* File: sim/avs_timebase_bench.sv */
// Self-checking bench for the presentation timebase block.
module avs_timebase_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [32:0] scr;
    logic [32:0] pts;
    logic        aud;
    logic [2:0]  vrd;
  } avs_row_t;
  // A short picture period keeps the repeat wait down to a few ticks.
  localparam logic [32:0] PER = 33'h0_0000_0002;
  localparam logic [32:0] S0  = 33'h0_0000_1000;
  localparam logic [32:0] MX  = avs_pkg::STAMP_MAX;
  logic        clk_in = 1'b0;
  logic        nrst_in, scr_valid_in, pic_valid_in, pic_is_audio_in, sleep_in, test_n_in;
  logic [32:0] scr_in, pic_pts_in, stc_out;
  logic        show_out, drop_out, repeat_out, audio_start_out, cpu_clk_en_out, test_mode_out;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n, reps, drops;
  avs_row_t    rows[5] = '{'{S0, S0, 1'b0, 3'h4}, '{S0, S0 + PER, 1'b0, 3'h4},
                           '{S0, S0 - 33'h1, 1'b0, 3'h2}, '{S0, S0 + 33'h1, 1'b1, 3'h1},
                           '{MX, 33'h0, 1'b0, 3'h2}};

  always #5 clk_in = ~clk_in;

  avs_timebase #(.PERIOD_TICKS(PER)) DUT (.clk_in(clk_in), .nrst_in(nrst_in),
    .scr_valid_in(scr_valid_in), .scr_in(scr_in), .pic_valid_in(pic_valid_in),
    .pic_pts_in(pic_pts_in), .pic_is_audio_in(pic_is_audio_in), .sleep_in(sleep_in),
    .test_n_in(test_n_in), .stc_out(stc_out), .show_out(show_out), .drop_out(drop_out),
    .repeat_out(repeat_out), .audio_start_out(audio_start_out),
    .cpu_clk_en_out(cpu_clk_en_out), .test_mode_out(test_mode_out));

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic load(input logic [32:0] v);
    scr_valid_in = 1'b1;
    scr_in = v;
    cyc(1);
    scr_valid_in = 1'b0;
    chk("stc_load", stc_out, v);
  endtask : load

  // Counts cycles until the system time moves; a stuck counter ends the run.
  task automatic wait_tick(output int k);
    logic [32:0] v;
    v = stc_out;
    k = 0;
    while (stc_out === v) begin
      cyc(1);
      k++;
      if (k > 1200) begin
        n_mismatch++;
        stop_test();
      end
    end
  endtask : wait_tick

  initial begin
    {nrst_in, scr_valid_in, pic_valid_in, pic_is_audio_in, sleep_in} = 5'h0;
    test_n_in = 1'b1;
    scr_in = '0;
    pic_pts_in = '0;
    cyc(10);
    chk("stc_rst", stc_out, avs_pkg::STAMP_RESET);
    chk("outs_rst", {show_out, drop_out, repeat_out, audio_start_out, test_mode_out},
        33'h0);
    chk("cpu_en_rst", cpu_clk_en_out, 33'h1);
    nrst_in = 1'b1;
    foreach (rows[i]) begin
      load(rows[i].scr);
      pic_valid_in = 1'b1;
      pic_pts_in = rows[i].pts;
      pic_is_audio_in = rows[i].aud;
      cyc(1);
      pic_valid_in = 1'b0;
      chk("verdict", {show_out, drop_out, audio_start_out}, rows[i].vrd);
      chk("repeat", repeat_out, 33'h0);
      cyc(1);
      chk("pulse_end", {show_out, drop_out, audio_start_out}, 33'h0);
    end
    pic_is_audio_in = 1'b0;
    load(MX);
    wait_tick(n);
    chk("wrap", stc_out, 33'h0);
    wait_tick(n);
    chk("tick_gap", 33'(n), 33'(avs_pkg::TICK_DIV));
    load(33'h0_0000_0100);
    pic_valid_in = 1'b1;
    pic_pts_in = 33'h0_0000_0105;
    cyc(1);
    pic_valid_in = 1'b0;
    chk("wait_quiet", {show_out, drop_out, repeat_out}, 33'h0);
    reps = 0;
    drops = 0;
    n = 0;
    while (show_out !== 1'b1) begin
      pic_valid_in = (n == 2);
      pic_pts_in = 33'h0;
      cyc(1);
      n++;
      reps += int'(repeat_out === 1'b1);
      drops += int'(drop_out === 1'b1);
      if (n > 4000) begin
        n_mismatch++;
        stop_test();
      end
    end
    // One repeat per tick until the stamp lies within one period of the time.
    chk("repeats", 33'(reps), 33'h0_0000_0105 - PER - 33'h0_0000_0100);
    chk("refused", 33'(drops), 33'h0);
    pic_is_audio_in = 1'b1;
    load(33'h0_0000_0200);
    pic_valid_in = 1'b1;
    pic_pts_in = 33'h0_0000_0200 + PER + 33'h1;
    cyc(1);
    pic_valid_in = 1'b0;
    pic_is_audio_in = 1'b0;
    wait_tick(n);
    chk("audio_rep", repeat_out, 33'h1);
    cyc(1);
    chk("audio_late", {show_out, drop_out, audio_start_out}, 33'h1);
    load(33'h0_0000_0300);
    pic_valid_in = 1'b1;
    pic_pts_in = 33'h0_0000_0310;
    cyc(1);
    pic_valid_in = 1'b0;
    load(33'h0_0000_0320);
    cyc(1);
    chk("wait_drop", {show_out, drop_out, repeat_out}, 33'h2);
    load(33'h0_0000_0400);
    pic_valid_in = 1'b1;
    pic_pts_in = 33'h0_0000_0410;
    cyc(1);
    pic_valid_in = 1'b0;
    nrst_in = 1'b0;
    cyc(10);
    chk("stc_rst2", stc_out, avs_pkg::STAMP_RESET);
    chk("outs_rst2", {show_out, drop_out, repeat_out, audio_start_out}, 33'h0);
    nrst_in = 1'b1;
    pic_valid_in = 1'b1;
    pic_pts_in = avs_pkg::STAMP_RESET;
    cyc(1);
    pic_valid_in = 1'b0;
    chk("rst_unit", {show_out, drop_out, repeat_out}, 33'h4);
    sleep_in = 1'b1;
    n = 0;
    repeat (32) begin
      cyc(1);
      n += int'(cpu_clk_en_out === 1'b1);
    end
    chk("sleep_en", 33'(n), 33'(32 / avs_pkg::SLEEP_DIV));
    sleep_in = 1'b0;
    cyc(1);
    chk("awake_en", cpu_clk_en_out, 33'h1);
    test_n_in = 1'b0;
    cyc(5);
    chk("test_on", test_mode_out, 33'h1);
    test_n_in = 1'b1;
    cyc(5);
    chk("test_off", test_mode_out, 33'h0);
    stop_test();
  end
endmodule : avs_timebase_bench
